// File: inc/ulb_pkg.sv
package ulb_pkg;
   // Mode register bit positions
   localparam int MODE_POWER_BIT = 7;
   localparam int MODE_TXE_BIT = 6;
   localparam int MODE_RXE_BIT = 5;
   localparam int MODE_MERGE_BIT = 0;
   // Control register bit positions
   localparam int CTRL_BRK_RX_BIT = 6;
   localparam int CTRL_BRK_TX_BIT = 5;
   localparam int CTRL_BLEN_LSB = 2;
   // Status bit positions
   localparam int STAT_OVR_BIT = 0;
   localparam int STAT_FRM_BIT = 1;
   localparam int STAT_PAR_BIT = 2;
   // Reset values and counts
   localparam logic [7:0] RXBUF_RESET = 8'hFF;
   localparam logic [7:0] DIV_RESET = 8'hFF;
   localparam logic [4:0] BRK_TX_BASE = 5'h0D;
   localparam logic [4:0] BRK_RX_MIN = 5'h0B;
   localparam int FILTER_DELAY = 2;

   typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} ulb_par_e;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} ulb_rx_e;

   typedef struct packed {
      logic power;
      logic tx_en;
      logic rx_en;
      ulb_par_e parity;
      logic len8;
      logic merge;
   } ulb_mode_s;

   typedef struct packed {
      logic par_err;
      logic frm_err;
      logic ovr_err;
   } ulb_err_s;
endpackage : ulb_pkg

// File: logic/ulb_filter.sv
`timescale 1ns/1ps
module ulb_filter
   import ulb_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic hold_i,
   input wire logic raw_i,
   output logic filt_o
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } ulb_flt_s;
   ulb_flt_s st, next_st;
   // =======================================
   // Match detector
   always_comb
   begin
      next_st = st;
      next_st.s1 = raw_i;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      if (hold_i)
         next_st.out = 1'b1;
      else if (st.s2 == st.s3)
         next_st.out = st.s3;
   end
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         st <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, out: 1'b1};
      else
         st <= next_st;
   end
   assign filt_o = st.out;
   property p_filter_lag;
      @(posedge clock_i) disable iff (rst_i)
      (!hold_i && st.s2 == st.s3 && !$past(hold_i)) |=> filt_o == $past(st.s3);
   endproperty
   a_filter_lag: assert property (p_filter_lag) else $error("filter output wrong");
endmodule : ulb_filter

// File: logic/ulb_rx_break.sv
`timescale 1ns/1ps
// How it works
// - power then receive enable starts sampling
// - falling edge, recheck low after divider
// - shift bits, stop copies buffer, interrupt
// - overrun keeps buffer unchanged
// - parity error reported at frame end
// - only one stop bit checked
// - status read returns flags then clears
// - parity, framing, overrun flag causes
// - any error at end raises error irq while merge bit is clear
// - merge bit routes errors to done irq
// - filtered input needs two agreeing samples
// - filter lags line by four cycles
// - transmit pin high once powered
// - break trigger with power and transmit enable sends break, unless a data write comes in the same cycle
// - break low 13 to 20 bit times
// - break end irq, trigger cleared
// - transmitter idles after break
// - break receive armed, normal start detect
// - break of 11 bits completes, clears bits
// - good break suppresses errors, no copy
// - short break stays armed silently
// - even or odd parity count check
// - zero or no parity never errors
// - baud counter cleared when disabled
module ulb_rx_break
   import ulb_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic serial_in_pin_i,
   input wire logic [7:0] mode_i,
   input wire logic [7:0] divider_i,
   input wire logic brk_len_wr_i,
   input wire logic [2:0] break_length_select_i,
   input wire logic break_send_set_i,
   input wire logic break_receive_set_i,
   input wire logic tx_data_write_i,
   input wire logic status_read_i,
   input wire logic buffer_read_i,
   output logic serial_out_pin_o,
   output logic [7:0] receive_buffer_o,
   output logic [2:0] receive_error_status_o,
   output logic break_send_trigger_o,
   output logic break_receive_trigger_o,
   output logic break_received_flag_o,
   output logic receive_done_irq_o,
   output logic receive_error_irq_o,
   output logic transmit_done_irq_o
);
   // =======================================
   // State
   typedef struct packed {
      ulb_rx_e rx;
      logic [7:0] baud;
      logic half;
      logic [3:0] bitn;
      logic [4:0] lowcnt;
      logic [7:0] shreg;
      logic par_acc;
      logic [7:0] rbuf;
      logic unread;
      ulb_err_s err;
      logic brk_tx;
      logic [2:0] blen;
      logic brk_rx;
      logic brk_flag;
      logic brk_tx_on;
      logic [5:0] tx_bits;
      logic [7:0] tx_baud;
      logic txd;
      logic prev;
      logic done_irq;
      logic err_irq;
      logic tx_irq;
   } ulb_st_s;
   ulb_st_s st, next_st;
   ulb_mode_s mode;
   logic filt;
   logic rx_on;
   logic baud_tick;
   logic tx_tick;
   logic [3:0] frame_bits;
   logic par_bit_used;
   logic stop_pos;
   logic par_bad;
   ulb_err_s new_err;
   logic [7:0] div_safe;
   logic [5:0] brk_ticks;

   assign mode = '{power: mode_i[MODE_POWER_BIT], tx_en: mode_i[MODE_TXE_BIT],
                   rx_en: mode_i[MODE_RXE_BIT], parity: ulb_par_e'(mode_i[4:3]),
                   len8: mode_i[2], merge: mode_i[MODE_MERGE_BIT]};
   assign rx_on = mode.power && mode.rx_en;
   // Divider below four is outside the usable range; clamp rather than spin
   assign div_safe = (divider_i < 8'h04) ? 8'h04 : divider_i;

   ulb_filter u_filter (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .hold_i(!rx_on),
      .raw_i(serial_in_pin_i),
      .filt_o(filt)
   );

   // One bit time is two divider periods; half is the phase toggle
   assign baud_tick = (st.baud == div_safe - 8'h01);
   assign tx_tick = (st.tx_baud == div_safe - 8'h01);
   // Break length in divider periods, two per bit time; 20 bits needs six bits
   assign brk_ticks = {BRK_TX_BASE + {2'h0, st.blen}, 1'b0};
   assign par_bit_used = (mode.parity != PAR_NONE);
   assign frame_bits = (mode.len8 ? 4'h8 : 4'h7) + {3'h0, par_bit_used};
   assign stop_pos = (st.bitn == frame_bits);
   assign par_bad = ((mode.parity == PAR_EVEN) && st.par_acc) ||
                    ((mode.parity == PAR_ODD) && !st.par_acc);

   always_comb
   begin
      next_st = st;
      next_st.done_irq = 1'b0;
      next_st.err_irq = 1'b0;
      next_st.tx_irq = 1'b0;
      next_st.prev = filt;
      new_err = '0;
      // =======================================
      // Receiver
      // counter cleared when disabled
      if (!rx_on)
      begin
         next_st.rx = RX_IDLE;
         next_st.baud = 8'h00;
         next_st.half = 1'b0;
      end
      else
      begin
         case (st.rx)
            RX_IDLE:
            begin
               // same start detect in break mode
               if (st.prev && !filt)
               begin
                  next_st.rx = RX_START;
                  next_st.baud = 8'h00;
                  next_st.half = 1'b0;
               end
            end
            RX_START:
            begin
               next_st.baud = baud_tick ? 8'h00 : st.baud + 8'h01;
               if (baud_tick)
               begin
                  if (filt)
                     next_st.rx = RX_IDLE;
                  else
                  begin
                     next_st.rx = RX_DATA;
                     next_st.half = 1'b0;
                     next_st.bitn = 4'h0;
                     next_st.lowcnt = 5'h01;
                     next_st.shreg = 8'h00;
                     next_st.par_acc = 1'b0;
                  end
               end
            end
            RX_DATA:
            begin
               next_st.baud = baud_tick ? 8'h00 : st.baud + 8'h01;
               if (baud_tick)
                  next_st.half = !st.half;
               if (baud_tick && st.half)
               begin
                  if (!filt && st.lowcnt != 5'h1F)
                     next_st.lowcnt = st.lowcnt + 5'h01;
                  if (st.brk_rx)
                  begin
                     // Break: wait for line high, then judge length
                     if (filt)
                     begin
                        next_st.rx = RX_IDLE;
                        if (st.lowcnt >= BRK_RX_MIN)
                        begin
                           next_st.done_irq = 1'b1;
                           next_st.brk_rx = 1'b0;
                           next_st.brk_flag = 1'b0;
                        end
                     end
                  end
                  else if (!stop_pos)
                  begin
                     next_st.bitn = st.bitn + 4'h1;
                     next_st.par_acc = st.par_acc ^ filt;
                     if (st.bitn < (mode.len8 ? 4'h8 : 4'h7))
                        next_st.shreg = mode.len8 ? {filt, st.shreg[7:1]}
                                                  : {1'b0, filt, st.shreg[6:1]};
                  end
                  else
                  begin
                     next_st.rx = RX_IDLE;
                     new_err.par_err = par_bad;
                     new_err.frm_err = !filt;
                     new_err.ovr_err = st.unread;
                     next_st.err = st.err | new_err;
                     if (!st.unread)
                     begin
                        next_st.rbuf = st.shreg;
                        next_st.unread = 1'b1;
                     end
                     if (new_err != '0 && !mode.merge)
                        next_st.err_irq = 1'b1;
                     else
                        next_st.done_irq = 1'b1;
                  end
               end
            end
            default: next_st.rx = RX_IDLE;
         endcase
      end
      if (status_read_i)
         next_st.err = new_err;
      if (buffer_read_i && !(next_st.unread && !st.unread))
         next_st.unread = 1'b0;
      // =======================================
      // Break receive arming
      if (break_receive_set_i && rx_on)
      begin
         next_st.brk_rx = 1'b1;
         next_st.brk_flag = 1'b1;
      end
      // =======================================
      // Break transmit
      if (brk_len_wr_i)
         next_st.blen = break_length_select_i;
      next_st.tx_baud = tx_tick ? 8'h00 : st.tx_baud + 8'h01;
      next_st.txd = 1'b1;
      if (!mode.power || !mode.tx_en)
      begin
         next_st.brk_tx = 1'b0;
         next_st.brk_tx_on = 1'b0;
         next_st.tx_baud = 8'h00;
      end
      else if (!st.brk_tx_on)
      begin
         if (break_send_set_i && !tx_data_write_i)
         begin
            next_st.brk_tx = 1'b1;
            next_st.brk_tx_on = 1'b1;
            next_st.tx_bits = 6'h00;
            next_st.tx_baud = 8'h00;
            // Line drops on the start edge so the low time is whole bit times
            next_st.txd = 1'b0;
         end
      end
      else
      begin
         next_st.txd = 1'b0;
         if (tx_tick)
            next_st.tx_bits = st.tx_bits + 6'h01;
         if (tx_tick && st.tx_bits == brk_ticks - 6'h01)
         begin
            next_st.brk_tx_on = 1'b0;
            next_st.brk_tx = 1'b0;
            next_st.tx_irq = 1'b1;
            next_st.txd = 1'b1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st <= '0;
         st.rx <= RX_IDLE;
         st.rbuf <= RXBUF_RESET;
         st.txd <= 1'b1;
         st.prev <= 1'b1;
      end
      else
         st <= next_st;
   end

   assign serial_out_pin_o = st.txd;
   assign receive_buffer_o = st.rbuf;
   assign receive_error_status_o = {st.err.par_err, st.err.frm_err, st.err.ovr_err};
   assign break_send_trigger_o = st.brk_tx;
   assign break_receive_trigger_o = st.brk_rx;
   assign break_received_flag_o = st.brk_flag;
   assign receive_done_irq_o = st.done_irq;
   assign receive_error_irq_o = st.err_irq;
   assign transmit_done_irq_o = st.tx_irq;

   // =======================================
   // Checks
   property p_idle_off;
      @(posedge clock_i) disable iff (rst_i)
      !rx_on |=> st.rx == RX_IDLE && st.baud == 8'h00;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("counter not cleared");
   property p_noise;
      @(posedge clock_i) disable iff (rst_i)
      (rx_on && st.rx == RX_START && baud_tick && filt) |=> st.rx == RX_IDLE && !receive_done_irq_o;
   endproperty
   a_noise: assert property (p_noise) else $error("noise start accepted");
   property p_ovr_keep;
      @(posedge clock_i) disable iff (rst_i)
      (rx_on && st.rx == RX_DATA && !st.brk_rx && baud_tick && st.half && stop_pos && st.unread
       && !buffer_read_i) |=> $stable(receive_buffer_o) && receive_error_status_o[STAT_OVR_BIT];
   endproperty
   a_ovr_keep: assert property (p_ovr_keep) else $error("overrun overwrote buffer");
   property p_read_clear;
      @(posedge clock_i) disable iff (rst_i)
      (status_read_i && !(st.rx == RX_DATA && baud_tick)) |=> receive_error_status_o == 3'h0;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("status not cleared");
   property p_err_irq;
      @(posedge clock_i) disable iff (rst_i)
      receive_error_irq_o |-> !mode.merge || $past(mode_i[MODE_MERGE_BIT]) == 1'b0;
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error irq with merge");
   property p_tx_high;
      @(posedge clock_i) disable iff (rst_i)
      (mode.power && !mode.tx_en) |=> serial_out_pin_o;
   endproperty
   a_tx_high: assert property (p_tx_high) else $error("tx pin not idle high");
   property p_brk_clear;
      @(posedge clock_i) disable iff (rst_i)
      transmit_done_irq_o |-> !break_send_trigger_o && serial_out_pin_o;
   endproperty
   a_brk_clear: assert property (p_brk_clear) else $error("break trigger kept");
   property p_brk_rx_end;
      @(posedge clock_i) disable iff (rst_i)
      $fell(break_receive_trigger_o) && mode.power && mode.rx_en |-> receive_done_irq_o &&
      !break_received_flag_o && $stable(receive_buffer_o);
   endproperty
   a_brk_rx_end: assert property (p_brk_rx_end) else $error("break end wrong");
   sequence s_fall_seen;
      rx_on && st.rx == RX_IDLE && st.prev && !filt;
   endsequence
   property p_start_seen;
      @(posedge clock_i) disable iff (rst_i)
      s_fall_seen |=> st.rx == RX_START && st.baud == 8'h00;
   endproperty
   a_start_seen: assert property (p_start_seen) else $error("start edge missed");
endmodule : ulb_rx_break

// File: dv/ulb_line_node.sv
`timescale 1ns/1ps
// ==========================================
// Remote node on the receive line
module ulb_line_node
   import ulb_pkg::*;
#(
   parameter int BIT = 16
)
(
   input wire logic clock_i,
   output logic line_o
);
   // Line idles high, as a pulled-up bus would
   initial line_o = 1'b1;

   task automatic send(input logic b, input int n);
      line_o <= b;
      repeat (n) @(posedge clock_i);
   endtask : send

   // LSB first, one stop bit, then idle long enough for the answer
   task automatic frame(input logic [7:0] d, input logic has_par, input logic p,
         input logic stop);
      send(1'b0, BIT);
      for (int i = 0; i < 8; i++)
         send(d[i], BIT);
      if (has_par)
         send(p, BIT);
      send(stop, BIT);
      send(1'b1, 2 * BIT);
   endtask : frame
endmodule : ulb_line_node

// File: dv/uart_receive_lin_break_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// Bench for the receiver and break logic
module uart_receive_lin_break_tb_top
   import ulb_pkg::*;
;
   localparam int DIV = 8;
   localparam int BIT = 2 * DIV;
   logic clock_i, rst_i, line, blw, bss, brs, txw, srd, brd;
   logic [7:0] mode, rbuf;
   logic [2:0] bls, stat;
   logic txd, bst, brt, brf, dirq, eirq, tirq;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   int n_done = 0, n_err = 0, n_tx = 0, e_done = 0, e_err = 0, e_tx = 0, low_cnt = 0;
   int low0 = 0;

   ulb_line_node #(.BIT(BIT)) node (.clock_i(clock_i), .line_o(line));

   ulb_rx_break uut (.clock_i(clock_i), .rst_i(rst_i), .serial_in_pin_i(line),
      .mode_i(mode), .divider_i(8'(DIV)), .brk_len_wr_i(blw),
      .break_length_select_i(bls), .break_send_set_i(bss), .break_receive_set_i(brs),
      .tx_data_write_i(txw), .status_read_i(srd), .buffer_read_i(brd),
      .serial_out_pin_o(txd), .receive_buffer_o(rbuf), .receive_error_status_o(stat),
      .break_send_trigger_o(bst), .break_receive_trigger_o(brt),
      .break_received_flag_o(brf), .receive_done_irq_o(dirq),
      .receive_error_irq_o(eirq), .transmit_done_irq_o(tirq));

   initial
   begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end

   // ==========================================
   // Event counters and hang guard
   always @(posedge clock_i)
   begin
      n_done <= n_done + int'(dirq === 1'b1);
      n_err <= n_err + int'(eirq === 1'b1);
      n_tx <= n_tx + int'(tirq === 1'b1);
      low_cnt <= low_cnt + int'(txd === 1'b0);
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         print_verdict();
      end
   end

   // ==========================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // 0 status read, 1 buffer read, 2 break send, 3 break receive, 4 length load,
   // 5 break send together with a data write
   task automatic strobe(input int k);
      case (k)
         0: srd <= 1'b1;
         1: brd <= 1'b1;
         2: bss <= 1'b1;
         3: brs <= 1'b1;
         5: {bss, txw} <= 2'b11;
         default: blw <= 1'b1;
      endcase
      @(posedge clock_i);
      {srd, brd, bss, brs, blw, txw} <= '0;
      @(posedge clock_i);
   endtask : strobe

   task automatic irqs();
      check(8'(n_done), 8'(e_done));
      check(8'(n_err), 8'(e_err));
      check(8'(n_tx), 8'(e_tx));
   endtask : irqs

   // Software order: status first, then buffer
   task automatic service(input logic [2:0] st);
      check({5'h00, stat}, {5'h00, st});
      strobe(0);
      check({5'h00, stat}, 8'h00);
      strobe(1);
   endtask : service

   task automatic print_verdict();
      $display("Checks %0d, errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict

   // ==========================================
   // Main sequence
   initial
   begin
      {blw, bss, brs, txw, srd, brd} = '0;
      mode = 8'h00;
      bls = 3'h0;
      rst_i = 1'b1;
      repeat (10) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      check(rbuf, RXBUF_RESET);
      check({5'h00, stat}, 8'h00);
      check({7'h00, txd}, 8'h01);
      mode <= 8'h80;
      node.frame(8'hA5, 1'b1, 1'b0, 1'b1);
      irqs();
      check({7'h00, txd}, 8'h01);
      mode <= 8'hFC;
      node.frame(8'hA5, 1'b1, 1'b0, 1'b1);
      e_done++;
      irqs();
      check(rbuf, 8'hA5);
      service(3'b000);
      // wrong parity bit for even then odd
      for (int m = 0; m < 2; m++)
      begin
         mode <= (m == 1) ? 8'hF4 : 8'hFC;
         node.frame(8'h3C, 1'b1, (m == 0), 1'b1);
         e_err++;
         irqs();
         service(3'b100);
      end
      mode <= 8'hFD;
      node.frame(8'h3C, 1'b1, 1'b1, 1'b1);
      e_done++;
      irqs();
      service(3'b100);
      mode <= 8'hEC;
      node.frame(8'h5A, 1'b1, 1'b1, 1'b1);
      e_done++;
      irqs();
      check(rbuf, 8'h5A);
      service(3'b000);
      mode <= 8'hE0;
      node.frame(8'hC5, 1'b0, 1'b0, 1'b1);
      e_done++;
      irqs();
      check(rbuf, 8'h45);
      service(3'b000);
      mode <= 8'hFC;
      node.frame(8'h81, 1'b1, 1'b0, 1'b0);
      e_err++;
      irqs();
      service(3'b010);
      node.frame(8'h11, 1'b1, 1'b0, 1'b1);
      node.frame(8'h22, 1'b1, 1'b0, 1'b1);
      e_done++;
      e_err++;
      irqs();
      check(rbuf, 8'h11);
      service(3'b001);
      // short glitch and failed start recheck
      node.send(1'b0, 1);
      node.send(1'b1, BIT);
      node.send(1'b0, 4);
      node.send(1'b1, 3 * BIT);
      irqs();
      for (int l = 0; l < 8; l += 7)
      begin
         bls <= 3'(l);
         strobe(4);
         low0 = low_cnt;
         strobe(2);
         check({7'h00, bst}, 8'h01);
         repeat ((13 + l) * BIT + 2 * BIT) @(posedge clock_i);
         check(8'((low_cnt - low0) / BIT), 8'(13 + l));
         check(8'((low_cnt - low0) % BIT), 8'h00);
         e_tx++;
         irqs();
         check({7'h00, bst}, 8'h00);
         check({7'h00, txd}, 8'h01);
      end
      low0 = low_cnt;
      strobe(5);
      repeat (BIT) @(posedge clock_i);
      check({7'h00, bst}, 8'h00);
      check(8'(low_cnt - low0), 8'h00);
      mode <= 8'hA4;
      low0 = low_cnt;
      strobe(2);
      repeat (BIT) @(posedge clock_i);
      check({7'h00, bst}, 8'h00);
      check(8'(low_cnt - low0), 8'h00);
      mode <= 8'hE4;
      strobe(3);
      check({7'h00, brt}, 8'h01);
      node.send(1'b0, 10 * BIT);
      node.send(1'b1, 3 * BIT);
      irqs();
      check({7'h00, brt}, 8'h01);
      strobe(0);
      node.send(1'b0, 11 * BIT);
      node.send(1'b1, 3 * BIT);
      e_done++;
      irqs();
      check({6'h00, brt, brf}, 8'h00);
      check({5'h00, stat}, 8'h00);
      check(rbuf, 8'h11);
      print_verdict();
   end
endmodule : uart_receive_lin_break_tb_top
